// ### hw/psc_pkg.sv
package psc_pkg;

  // ---------------------------------------------------------------
  // Clock and timing.
  // ---------------------------------------------------------------
  localparam int CLK_MHZ = 250;
  localparam int BLINK_TIME_US = 50000;
  localparam int BLINK_CYCLES = BLINK_TIME_US * CLK_MHZ;

  // ---------------------------------------------------------------
  // Register indices; the APB byte address is four times the index.
  // ---------------------------------------------------------------
  localparam logic [7:0] IDX_BASIC_CTRL = 8'h00;
  localparam logic [7:0] IDX_AN_ADV = 8'h04;
  localparam logic [7:0] IDX_STRAP_STAT = 8'h10;
  localparam logic [7:0] IDX_IND_CTRL = 8'h1e;

  // Basic control fields.
  localparam int BIT_SPEED = 13;
  localparam int BIT_AUTONEG = 12;
  localparam int BIT_ISOLATE = 10;
  localparam int BIT_DUPLEX = 8;
  // Advertisement fields.
  localparam int BIT_ADV_100_FD = 8;
  localparam int BIT_ADV_100_HD = 7;
  localparam int BIT_ADV_10_FD = 6;
  localparam int BIT_ADV_10_HD = 5;
  localparam logic [4:0] ADV_SELECTOR = 5'h01;
  // Strap status fields.
  localparam int STAT_ADDR_LO = 0;
  localparam int STAT_MODE_LO = 8;
  localparam int STAT_FIBER = 12;
  localparam int STAT_FEF = 13;
  localparam int STAT_SIG_DET = 14;
  localparam int STAT_LINK = 15;
  // Indicator control field.
  localparam int IND_MODE_LO = 14;

  // ---------------------------------------------------------------
  // Reset values and encodings.
  // ---------------------------------------------------------------
  localparam logic [4:0] PHY_ADDR_DEFAULT = 5'h01;
  localparam logic [1:0] IND_MODE_LINKACT = 2'h0;
  localparam logic [1:0] IND_MODE_LINK = 2'h1;
  localparam logic [2:0] IF_MII = 3'h0;
  localparam logic [2:0] IF_RMII = 3'h1;
  localparam logic [2:0] IF_SMII = 3'h2;
  localparam logic [2:0] IF_MII_PRE = 3'h4;
  localparam logic [2:0] IF_RMII_B2B = 3'h5;
  localparam logic [2:0] IF_MII_B2B = 3'h6;

  // Strap vector positions.
  localparam int STRAP_W = 11;
  localparam int S_PHY_ADDRESS_STRAP_BIT0 = 0;
  localparam int S_PHY_ADDRESS_STRAP_BIT1 = 1;
  localparam int S_PHY_ADDRESS_STRAP_BIT2 = 2;
  localparam int S_CFG0 = 3;
  localparam int S_CFG1 = 4;
  localparam int S_CFG2 = 5;
  localparam int S_DUPLEX = 6;
  localparam int S_ISO = 7;
  localparam int S_SPEED = 8;
  localparam int S_NWAY = 9;
  localparam int S_FIBER = 10;

  // Serial segment framing.
  localparam logic [3:0] SEG_BITS = 4'd10;
  localparam logic [3:0] BYTE_BITS = 4'd8;
  localparam logic [3:0] SEG_REPEAT_10M = 4'd10;

endpackage

// ### hw/psc_led_drive.sv
`timescale 1ns/1ps
`default_nettype none
module psc_led_drive #(
  parameter int BLINK_CYCLES = psc_pkg::BLINK_CYCLES
) (
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_rst_b,
  // Status from the transceiver.
  input wire logic [1:0] i_mode,
  input wire logic i_link_up,
  input wire logic i_activity,
  input wire logic i_speed_100,
  // Indicator levels.
  output logic o_ind0,
  output logic o_ind1
);

  typedef struct packed {
    logic [31:0] cnt;
    logic phase;
    logic ind0;
    logic ind1;
  } psc_led_state_type;

  psc_led_state_type r_reg;
  psc_led_state_type r_next;

  // Blink divider toggles the blink phase; indicators idle high (off).
  always_comb
  begin
    r_next = r_reg;
    if (r_reg.cnt >= 32'(BLINK_CYCLES - 1))
    begin
      r_next.cnt = 32'h0;
      r_next.phase = ~r_reg.phase;
    end
    else
    begin
      r_next.cnt = r_reg.cnt + 32'h1;
    end
    unique case (i_mode)
      psc_pkg::IND_MODE_LINKACT:
      begin
        r_next.ind0 = i_activity ? r_reg.phase : ~i_link_up;
        r_next.ind1 = ~i_speed_100;
      end
      psc_pkg::IND_MODE_LINK:
      begin
        r_next.ind0 = ~i_link_up;
        r_next.ind1 = i_activity ? r_reg.phase : 1'b1;
      end
      default:
      begin
        r_next.ind0 = 1'b1;
        r_next.ind1 = 1'b1;
      end
    endcase
    if (!i_rst_b)
    begin
      r_next = '{ind0: 1'b1, ind1: 1'b1, default: '0};
    end
  end

  // State register.
  always_ff @(posedge i_clk)
  begin
    r_reg <= r_next;
  end

  assign o_ind0 = r_reg.ind0;
  assign o_ind1 = r_reg.ind1;

  a_ind_link_only: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (i_mode == psc_pkg::IND_MODE_LINK) |=> (o_ind0 == !$past(i_link_up)))
    else $error("Indicator 0 does not follow link in link mode.");
  a_ind_speed: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (i_mode == psc_pkg::IND_MODE_LINKACT) |=> (o_ind1 == !$past(i_speed_100)))
    else $error("Indicator 1 does not show speed.");
  a_ind_reserved: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    i_mode[1] |=> (o_ind0 && o_ind1))
    else $error("Reserved indicator mode is not off.");

endmodule
`default_nettype wire

// ### hw/psc_strap_top.sv
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Strap pins are inputs during reset; after it, indicator pins and, unless isolated, receive pins become outputs.
// - Three address straps give PHY address 0..7; default is 00001.
// - PHY address bits 4 and 3 are always zero.
// - Three interface straps select MII, RMII, SMII and their variants.
// - Isolate strap loads control bit 10; high isolates.
// - Copper speed strap loads control bit 13; high is 100 Mbps.
// - Speed strap also sets advertised 100 Mbps capability.
// - Duplex strap loads control bit 8; high is half duplex.
// - Copper auto-negotiation strap loads control bit 12; high enables.
// - Fiber operation always disables auto-negotiation.
// - In fiber, speed strap is latched as the far-end-fault option.
// - Fiber-enable low selects copper, high 100 Mbps fiber; pin also detects signal.
// - Both indicators follow a two-bit mode field; codes 10 and 11 reserved.
// - Indicator 0 shows link with activity blink, or link only.
// - Indicator 1 shows speed, or activity blink.
// - Active-low reset resets the block and samples straps again.
// - MII receive nibbles are valid only while receive-valid is high.
// - RMII moves two bits per clock while data valid or enable is high.
// - SMII uses ten-bit segments, repeated ten times at 10 Mbps.
module psc_strap_top #(
  parameter int BLINK_CYCLES = psc_pkg::BLINK_CYCLES
) (
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_rst_b,
  // APB slave.
  input wire logic [11:0] i_paddr,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [31:0] i_pwdata,
  output logic o_pready,
  output logic [31:0] o_prdata,
  output logic o_pslverr,
  // Receive pins, two-way: {rxd3, rxd2, rxd1, rxd0}.
  input wire logic [3:0] i_rxd,
  output logic [3:0] o_rxd,
  output logic o_rxd_oe,
  // Receive control pins, two-way: {crs, col, rxer, rxdv}.
  input wire logic [3:0] i_rx_ctl,
  output logic [3:0] o_rx_ctl,
  output logic o_rx_ctl_oe,
  // Indicator pins, two-way.
  input wire logic i_indicator_out_zero,
  output logic o_indicator_out_zero,
  output logic o_indicator_out_zero_oe,
  input wire logic i_indicator_out_one,
  output logic o_indicator_out_one,
  output logic o_indicator_out_one_oe,
  // Fiber enable and signal detect pin.
  input wire logic i_fiber_enable,
  // Link clock and transmit pins: {tx_en, txd3, txd2, txd1, txd0}.
  input wire logic i_link_clk,
  input wire logic [4:0] i_tx_pins,
  // Core receive source.
  input wire logic [7:0] i_rx_data,
  input wire logic i_rx_dv,
  input wire logic i_rx_err,
  input wire logic i_carrier,
  input wire logic i_collision,
  output logic o_rx_take,
  // Core transmit sink.
  output logic [7:0] o_tx_data,
  output logic o_tx_valid,
  output logic o_tx_err,
  // Core status.
  input wire logic i_link_up,
  input wire logic i_activity,
  input wire logic i_link_speed_100,
  // Latched configuration.
  output logic [4:0] o_phy_addr,
  output logic [2:0] o_if_mode,
  output logic o_fiber_mode,
  output logic o_far_end_fault_en,
  output logic o_speed_100,
  output logic o_duplex_half,
  output logic o_autoneg_en,
  output logic o_isolate
);

  typedef struct packed {
    logic [psc_pkg::STRAP_W-1:0] s1;
    logic [psc_pkg::STRAP_W-1:0] s2;
    logic [2:0] lk;
    logic [4:0] t1;
    logic [4:0] t2;
    logic load_pend;
    logic drive_en;
    logic [4:0] phy_addr;
    logic [2:0] if_mode;
    logic fiber;
    logic fef;
    logic speed;
    logic autoneg;
    logic isolate;
    logic duplex;
    logic [3:0] adv;
    logic [1:0] ind_mode;
    logic [31:0] prdata;
    logic [9:0] rx_sh;
    logic [9:0] rx_hold;
    logic [3:0] rx_cnt;
    logic [3:0] rx_rep;
    logic [3:0] rxd_q;
    logic [3:0] rx_ctl_q;
    logic rx_take;
    logic [9:0] tx_sh;
    logic [3:0] tx_cnt;
    logic [3:0] tx_rep;
    logic [7:0] tx_data;
    logic tx_valid;
    logic tx_err;
  } psc_state_type;

  localparam psc_state_type ST_RESET = '{
    load_pend: 1'b1,
    phy_addr: psc_pkg::PHY_ADDR_DEFAULT,
    speed: 1'b1,
    autoneg: 1'b1,
    duplex: 1'b1,
    adv: 4'hf,
    default: '0
  };

  psc_state_type r_reg;
  psc_state_type r_next;

  // Bits moved per link clock edge for an interface mode.
  function automatic logic [3:0] lane_width(input logic [2:0] mode);
    unique case (mode)
      psc_pkg::IF_RMII, psc_pkg::IF_RMII_B2B: lane_width = 4'd2;
      psc_pkg::IF_SMII: lane_width = 4'd1;
      default: lane_width = 4'd4;
    endcase
  endfunction

  // Mask selecting the active lanes.
  function automatic logic [3:0] lane_mask(input logic [3:0] w);
    unique case (w)
      4'd1: lane_mask = 4'h1;
      4'd2: lane_mask = 4'h3;
      default: lane_mask = 4'hf;
    endcase
  endfunction

  // Shifts w bits in at the top; the earliest bit ends lowest.
  function automatic logic [9:0] shift_in(input logic [9:0] sh, input logic [3:0] b,
                                          input logic [3:0] w);
    unique case (w)
      4'd1: shift_in = {b[0], sh[9:1]};
      4'd2: shift_in = {b[1:0], sh[9:2]};
      default: shift_in = {b, sh[9:4]};
    endcase
  endfunction

  // Read data for a register index.
  function automatic logic [31:0] read_word(input psc_state_type s, input logic [7:0] idx,
                                            input logic link);
    read_word = 32'h0;
    unique case (idx)
      psc_pkg::IDX_BASIC_CTRL:
      begin
        read_word[psc_pkg::BIT_SPEED] = s.speed;
        read_word[psc_pkg::BIT_AUTONEG] = s.autoneg & ~s.fiber;
        read_word[psc_pkg::BIT_ISOLATE] = s.isolate;
        read_word[psc_pkg::BIT_DUPLEX] = s.duplex;
      end
      psc_pkg::IDX_AN_ADV:
      begin
        read_word[psc_pkg::BIT_ADV_100_FD:psc_pkg::BIT_ADV_10_HD] = s.adv;
        read_word[4:0] = psc_pkg::ADV_SELECTOR;
      end
      psc_pkg::IDX_STRAP_STAT:
      begin
        read_word[psc_pkg::STAT_ADDR_LO +: 5] = s.phy_addr;
        read_word[psc_pkg::STAT_MODE_LO +: 3] = s.if_mode;
        read_word[psc_pkg::STAT_FIBER] = s.fiber;
        read_word[psc_pkg::STAT_FEF] = s.fef;
        read_word[psc_pkg::STAT_SIG_DET] = s.fiber & s.s2[psc_pkg::S_FIBER];
        read_word[psc_pkg::STAT_LINK] = link;
      end
      psc_pkg::IDX_IND_CTRL: read_word[psc_pkg::IND_MODE_LO +: 2] = s.ind_mode;
      default: read_word = 32'h0;
    endcase
  endfunction

  // Register map decode.
  function automatic logic is_mapped(input logic [11:0] addr);
    is_mapped = (addr[1:0] == 2'h0) &&
                ((addr[9:2] == psc_pkg::IDX_BASIC_CTRL) || (addr[9:2] == psc_pkg::IDX_AN_ADV) ||
                 (addr[9:2] == psc_pkg::IDX_STRAP_STAT) || (addr[9:2] == psc_pkg::IDX_IND_CTRL)) &&
                (addr[11:10] == 2'h0);
  endfunction

  logic [psc_pkg::STRAP_W-1:0] strap_pins;
  logic apb_write;
  logic link_rise;
  logic link_fall;

  // Strap sources on the shared pins.
  assign strap_pins = {i_fiber_enable, i_indicator_out_zero, i_indicator_out_one, i_rx_ctl[1],
                       i_rxd[0], i_rx_ctl[0], i_rx_ctl[3], i_rx_ctl[2], i_rxd[1], i_rxd[2],
                       i_rxd[3]};
  assign apb_write = i_psel & i_penable & i_pwrite & is_mapped(i_paddr);
  // Edges of the synchronised link clock; stage lk[0] is read only by lk[1].
  assign link_rise = r_reg.lk[1] & ~r_reg.lk[2];
  assign link_fall = ~r_reg.lk[1] & r_reg.lk[2];

  // Next-state logic: synchronisers, strap load, registers and link framing.
  always_comb
  begin
    logic [3:0] w;
    logic [9:0] cur;
    logic [3:0] cnt;
    logic [9:0] tsh;
    logic [3:0] tcnt;
    logic smii;
    w = lane_width(r_reg.if_mode);
    smii = (r_reg.if_mode == psc_pkg::IF_SMII);
    cur = r_reg.rx_sh;
    cnt = r_reg.rx_cnt;
    tsh = r_reg.tx_sh;
    tcnt = r_reg.tx_cnt;
    r_next = r_reg;
    r_next.rx_take = 1'b0;
    r_next.tx_valid = 1'b0;
    r_next.tx_err = 1'b0;
    if (r_reg.load_pend)
    begin
      // Straps are loaded once, in the first cycle after release.
      r_next.load_pend = 1'b0;
      r_next.drive_en = 1'b1;
      r_next.phy_addr = {2'b00, r_reg.s2[psc_pkg::S_PHY_ADDRESS_STRAP_BIT2], r_reg.s2[psc_pkg::S_PHY_ADDRESS_STRAP_BIT1],
                         r_reg.s2[psc_pkg::S_PHY_ADDRESS_STRAP_BIT0]};
      r_next.if_mode = {r_reg.s2[psc_pkg::S_CFG2], r_reg.s2[psc_pkg::S_CFG1],
                        r_reg.s2[psc_pkg::S_CFG0]};
      r_next.fiber = r_reg.s2[psc_pkg::S_FIBER];
      r_next.isolate = r_reg.s2[psc_pkg::S_ISO];
      r_next.duplex = r_reg.s2[psc_pkg::S_DUPLEX];
      if (r_reg.s2[psc_pkg::S_FIBER])
      begin
        r_next.fef = r_reg.s2[psc_pkg::S_SPEED];
        r_next.autoneg = 1'b0;
        r_next.speed = 1'b1;
      end
      else
      begin
        r_next.speed = r_reg.s2[psc_pkg::S_SPEED];
        r_next.autoneg = r_reg.s2[psc_pkg::S_NWAY];
        r_next.adv[3:2] = {2{r_reg.s2[psc_pkg::S_SPEED]}};
      end
    end
    else
    begin
      // Setup phase captures read data so the access phase needs no wait.
      if (i_psel && !i_penable)
      begin
        r_next.prdata = read_word(r_reg, i_paddr[9:2], i_link_up);
      end
      if (apb_write)
      begin
        unique case (i_paddr[9:2])
          psc_pkg::IDX_BASIC_CTRL:
          begin
            r_next.speed = i_pwdata[psc_pkg::BIT_SPEED] | r_reg.fiber;
            r_next.autoneg = i_pwdata[psc_pkg::BIT_AUTONEG] & ~r_reg.fiber;
            r_next.isolate = i_pwdata[psc_pkg::BIT_ISOLATE];
            r_next.duplex = i_pwdata[psc_pkg::BIT_DUPLEX];
          end
          psc_pkg::IDX_AN_ADV:
            r_next.adv = i_pwdata[psc_pkg::BIT_ADV_100_FD:psc_pkg::BIT_ADV_10_HD];
          psc_pkg::IDX_IND_CTRL: r_next.ind_mode = i_pwdata[psc_pkg::IND_MODE_LO +: 2];
          default: r_next.prdata = r_reg.prdata;
        endcase
      end
      // Receive side moves on the rising link edge.
      if (link_rise)
      begin
        if (smii)
        begin
          if (r_reg.t2[1])
          begin
            // Sync starts a segment; at 10 Mbps one byte spans ten segments.
            if (r_reg.rx_rep == 4'd0)
            begin
              r_next.rx_hold = {i_rx_data, i_rx_dv, i_carrier};
              cur = {i_rx_data, i_rx_dv, i_carrier};
              r_next.rx_take = i_rx_dv;
            end
            else
            begin
              cur = r_reg.rx_hold;
            end
            cnt = psc_pkg::SEG_BITS;
            r_next.rx_rep = (r_reg.speed || r_reg.rx_rep == psc_pkg::SEG_REPEAT_10M - 4'd1) ?
                            4'd0 : r_reg.rx_rep + 4'd1;
          end
        end
        else if (cnt == 4'd0 && i_rx_dv)
        begin
          cur = {2'b00, i_rx_data};
          cnt = psc_pkg::BYTE_BITS;
          r_next.rx_take = 1'b1;
        end
        r_next.rxd_q = (cnt == 4'd0) ? 4'h0 : (cur[3:0] & lane_mask(w));
        r_next.rx_ctl_q = {i_carrier & ~smii, i_collision & ~smii,
                           i_rx_err & (cnt != 4'd0) & ~smii,
                           ~smii & ((cnt != 4'd0) |
                                    (i_carrier & (w == 4'd2)))};
        r_next.rx_sh = cur >> w;
        r_next.rx_cnt = (cnt >= w) ? cnt - w : 4'd0;
      end
      // Transmit pins are sampled on the falling link edge, mid-bit.
      if (link_fall)
      begin
        tsh = shift_in(r_reg.tx_sh, r_reg.t2[3:0] & lane_mask(w), w);
        if (smii)
        begin
          tcnt = r_reg.t2[1] ? 4'd1 : ((r_reg.tx_cnt == psc_pkg::SEG_BITS) ?
                 psc_pkg::SEG_BITS : r_reg.tx_cnt + 4'd1);
          if (tcnt == psc_pkg::SEG_BITS && r_reg.tx_cnt != psc_pkg::SEG_BITS)
          begin
            if (tsh[1] && (r_reg.speed || r_reg.tx_rep == 4'd0))
            begin
              r_next.tx_data = tsh[9:2];
              r_next.tx_valid = 1'b1;
              r_next.tx_err = tsh[0];
            end
            r_next.tx_rep = (r_reg.speed || r_reg.tx_rep == psc_pkg::SEG_REPEAT_10M - 4'd1) ?
                            4'd0 : r_reg.tx_rep + 4'd1;
          end
        end
        else if (!r_reg.t2[4])
        begin
          tcnt = 4'd0;
        end
        else
        begin
          tcnt = r_reg.tx_cnt + w;
          if (tcnt == psc_pkg::BYTE_BITS)
          begin
            r_next.tx_data = tsh[9:2];
            r_next.tx_valid = 1'b1;
            tcnt = 4'd0;
          end
        end
        r_next.tx_sh = tsh;
        r_next.tx_cnt = tcnt;
      end
    end
    if (!i_rst_b)
    begin
      r_next = ST_RESET;
    end
    // Synchronisers keep sampling through reset so straps are settled at release.
    r_next.s1 = strap_pins;
    r_next.s2 = r_reg.s1;
    r_next.lk = {r_reg.lk[1:0], i_link_clk};
    r_next.t1 = i_tx_pins;
    r_next.t2 = r_reg.t1;
  end

  // State register.
  always_ff @(posedge i_clk)
  begin
    r_reg <= r_next;
  end

  // Indicator driver.
  psc_led_drive #(
    .BLINK_CYCLES(BLINK_CYCLES)
  ) u_led (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_mode(r_reg.ind_mode),
    .i_link_up(i_link_up),
    .i_activity(i_activity),
    .i_speed_100(i_link_speed_100),
    .o_ind0(o_indicator_out_zero),
    .o_ind1(o_indicator_out_one)
  );

  // Bus answers and pin drive; isolation releases the receive pins.
  assign o_pready = 1'b1;
  assign o_pslverr = i_psel & i_penable & ~is_mapped(i_paddr);
  assign o_prdata = r_reg.prdata;
  assign o_rxd = r_reg.rxd_q;
  assign o_rx_ctl = r_reg.rx_ctl_q;
  assign o_rxd_oe = r_reg.drive_en & ~r_reg.isolate;
  assign o_rx_ctl_oe = r_reg.drive_en & ~r_reg.isolate;
  assign o_indicator_out_zero_oe = r_reg.drive_en;
  assign o_indicator_out_one_oe = r_reg.drive_en;
  assign o_rx_take = r_reg.rx_take;
  assign o_tx_data = r_reg.tx_data;
  assign o_tx_valid = r_reg.tx_valid;
  assign o_tx_err = r_reg.tx_err;
  assign o_phy_addr = r_reg.phy_addr;
  assign o_if_mode = r_reg.if_mode;
  assign o_fiber_mode = r_reg.fiber;
  assign o_far_end_fault_en = r_reg.fef;
  assign o_speed_100 = r_reg.speed;
  assign o_duplex_half = r_reg.duplex;
  assign o_autoneg_en = r_reg.autoneg & ~r_reg.fiber;
  assign o_isolate = r_reg.isolate;

  a_pins_in_reset: assert property (@(posedge i_clk)
    !i_rst_b |=> (!o_rxd_oe && !o_rx_ctl_oe && !o_indicator_out_zero_oe))
    else $error("Strap pins are driven during reset.");
  a_addr_upper_zero: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    o_phy_addr[4:3] == 2'b00)
    else $error("PHY address upper bits are not zero.");
  a_addr_from_strap: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    $rose(r_reg.drive_en) |-> (o_phy_addr[2:0] == {$past(r_reg.s2[2]), $past(r_reg.s2[1]),
                                                 $past(r_reg.s2[0])}))
    else $error("PHY address does not match straps.");
  a_load_once: assert property (@(posedge i_clk)
    (!i_rst_b ##1 i_rst_b) |=> (r_reg.drive_en && !r_reg.load_pend) [*2])
    else $error("Straps not loaded once after release.");
  a_fiber_no_an: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    o_fiber_mode |-> !o_autoneg_en)
    else $error("Auto-negotiation enabled in fiber operation.");
  a_iso_strap: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    $rose(r_reg.drive_en) |-> (o_isolate == $past(r_reg.s2[psc_pkg::S_ISO])))
    else $error("Isolate bit does not match strap.");
  a_tx_ignored: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (link_fall && !r_reg.t2[4] && o_if_mode != psc_pkg::IF_SMII) |=> !o_tx_valid)
    else $error("Transmit word taken while enable low.");
  a_rx_valid_data: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (!o_rx_ctl[0] && o_if_mode == psc_pkg::IF_MII) |-> (o_rxd == 4'h0))
    else $error("Receive data not idle while valid low.");

endmodule
`default_nettype wire

// ### bench/psc_mac_model.sv
`timescale 1ns/1ps
`default_nettype none
module psc_mac_model (
  // Frame request.
  input wire logic i_go,
  input wire logic [7:0] i_byte,
  // Link pins.
  output logic o_link_clk,
  output logic [4:0] o_tx_pins
);
  int k;
  // The link clock rests low outside frames.
  initial
  begin
    o_link_clk = 1'b0;
    o_tx_pins = 5'h00;
  end
  // Low nibble first, then enable drops over scrambled data.
  // Pins change on the rising link edge and stand across the falling one, where they are taken.
  // The short offset keeps link edges away from the sampling clock edge.
  always @(posedge i_go)
  begin
    #1;
    for (k = 0; k < 3; k++)
    begin
      #24 o_link_clk = 1'b1;
      o_tx_pins = (k == 2) ? {1'b0, ~o_tx_pins[3:0]} : {1'b1, i_byte[k*4 +: 4]};
      #24 o_link_clk = 1'b0;
    end
  end
endmodule
`default_nettype wire

// ### bench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic i_clk = 1'b0;
  logic i_rst_b = 1'b0;
  logic [11:0] pa = 12'h000;
  logic ps = 1'b0, pe = 1'b0, pw = 1'b0, go = 1'b0, lk = 1'b0, act = 1'b0, err;
  logic [31:0] wd = 32'h0, q, seed = 32'h0000dc4f;
  logic [10:0] s = 11'h341;
  logic [7:0] tb = 8'h00, txd;
  logic [7:0] rxb = 8'h00, rcv;
  logic rdv = 1'b0, spd = 1'b0, tk, seen;
  logic [2:0] modes [6] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5, 3'h6};
  logic rdy, serr, xoe, coe, z, zoe, o, ooe, lclk, txv, fib, fef, sp, dh, an, iso;
  logic [31:0] rd;
  logic [3:0] xo, co;
  logic [4:0] txp, adr;
  logic [2:0] md;
  int n_fail = 0;
  int n_checks = 0;
  // Shared pins carry the strap level until the block drives them.
  wire logic [3:0] xp = xoe ? xo : {s[0], s[1], s[2], s[6]};
  wire logic [3:0] cp = coe ? co : {s[4], s[3], s[7], s[5]};
  wire logic zp = zoe ? z : s[9];
  wire logic op = ooe ? o : s[8];
  always #2 i_clk = ~i_clk;
  psc_mac_model mac_u (.i_go(go), .i_byte(tb), .o_link_clk(lclk), .o_tx_pins(txp));
  psc_strap_top #(.BLINK_CYCLES(8)) dut_u (.i_clk(i_clk), .i_rst_b(i_rst_b),
    .i_paddr(pa), .i_psel(ps), .i_penable(pe), .i_pwrite(pw), .i_pwdata(wd),
    .o_pready(rdy), .o_prdata(rd), .o_pslverr(serr), .i_rxd(xp), .o_rxd(xo),
    .o_rxd_oe(xoe), .i_rx_ctl(cp), .o_rx_ctl(co), .o_rx_ctl_oe(coe),
    .i_indicator_out_zero(zp), .o_indicator_out_zero(z), .o_indicator_out_zero_oe(zoe),
    .i_indicator_out_one(op), .o_indicator_out_one(o), .o_indicator_out_one_oe(ooe),
    .i_fiber_enable(s[10]), .i_link_clk(lclk), .i_tx_pins(txp), .i_rx_data(rxb),
    .i_rx_dv(rdv), .i_rx_err(1'b0), .i_carrier(1'b0), .i_collision(1'b0), .o_rx_take(tk),
    .o_tx_data(txd), .o_tx_valid(txv), .o_tx_err(), .i_link_up(lk), .i_activity(act),
    .i_link_speed_100(spd), .o_phy_addr(adr), .o_if_mode(md), .o_fiber_mode(fib),
    .o_far_end_fault_en(fef), .o_speed_100(sp), .o_duplex_half(dh), .o_autoneg_en(an),
    .o_isolate(iso));
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // One APB transfer; the request stands until pready is seen high.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int t;
    ps <= 1'b1;
    pw <= w;
    pa <= a;
    wd <= d;
    @(posedge i_clk);
    pe <= 1'b1;
    for (t = 0; t < 20 && !(rdy === 1'b1 && t > 0); t++)
      @(posedge i_clk);
    if (t == 20)
    begin
      n_fail++;
      wrap_up();
    end
    q = rd;
    err = serr;
    ps <= 1'b0;
    pe <= 1'b0;
    @(posedge i_clk);
  endtask
  // Reset with a strap set, then compare the latched setup with the model.
  task automatic boot(input logic [10:0] v);
    logic f;
    f = v[10];
    i_rst_b <= 1'b0;
    s <= v;
    repeat (10) @(posedge i_clk);
    chk({xoe, zoe, ooe}, 0);
    i_rst_b <= 1'b1;
    repeat (2) @(posedge i_clk);
    chk(adr, {2'b00, v[2:0]});
    chk(md, v[5:3]);
    chk({fib, iso, dh}, {f, v[7], v[6]});
    chk({sp, an, fef}, {f | v[8], ~f & v[9], f & v[8]});
    chk({xoe, zoe, ooe}, {~v[7], 2'b11});
    apb(1'b0, 12'h000, 0);
    chk(q & 32'h3500, {f | v[8], ~f & v[9], 1'b0, v[7], 1'b0, v[6], 8'h00});
    apb(1'b0, 12'h010, 0);
    if (!f)
      chk({q[8:7], q[4:0]}, {v[8], v[8], 5'h01});
  endtask
  initial
  begin
    logic [10:0] v;
    int n;
    for (int i = 0; i < 6; i++)
    begin
      seed = lfsr(seed);
      v = {i[0], seed[9:6], modes[i], seed[2:0] | {2'b00, seed[2:0] == 3'h0}};
      boot(i == 0 ? 11'h341 : v);
    end
    boot(11'h341);
    apb(1'b1, 12'h000, 32'h2000);
    apb(1'b0, 12'h000, 0);
    chk(q & 32'h3500, 32'h2000);
    chk({sp, an, dh}, 3'b100);
    apb(1'b0, 12'h004, 0);
    chk({err, q[30:0]}, 32'h80000000);
    for (int m = 0; m < 3; m++)
    begin
      apb(1'b1, 12'h078, m << 14);
      for (int l = 0; l < 2; l++)
      begin
        lk <= l[0];
        spd <= ~l[0];
        repeat (4) @(posedge i_clk);
        chk({z, o}, m == 2 ? 2'b11 : {~l[0], m == 0 ? l[0] : 1'b1});
      end
    end
    apb(1'b1, 12'h078, 32'h4000);
    act <= 1'b1;
    n = 0;
    repeat (40) @(posedge i_clk) n += o;
    chk(n > 0 && n < 40, 1);
    // One frame each way: the core offers a byte while the MAC sends one.
    tb <= seed[15:8];
    rxb <= seed[23:16];
    rdv <= 1'b1;
    go <= 1'b1;
    @(posedge i_clk);
    go <= 1'b0;
    seen = 1'b0;
    rcv = 8'h00;
    for (n = 0; n < 200 && txv !== 1'b1; n++)
    begin
      @(posedge i_clk);
      if (tk === 1'b1)
        rdv <= 1'b0;
      if (co[0] === 1'b1)
      begin
        if (!seen)
          rcv[3:0] = xo;
        rcv[7:4] = xo;
        seen = 1'b1;
      end
    end
    if (n == 200)
      n_fail++;
    chk(txd, seed[15:8]);
    chk({rdv, rcv}, {1'b0, seed[23:16]});
    wrap_up();
  end
endmodule
`default_nettype wire
